// ==== bbcx_exec.sv ====
`timescale 1ns/1ps
module bbcx_exec
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // execution results
    output logic busy,
    output logic [7:0] result,
    output logic result_write,
    output logic [7:0] push_low,
    output logic [7:0] push_high
);
    import bbcx_pkg::*;

    // ----------------------------------------------------------------
    // programming model
    // ----------------------------------------------------------------
    // word offsets on the bus:
    //   0x000 control, bit 0 starts the loaded instruction
    //   0x004 instruction word, opcode in bits 23:16, then bytes 2 and 3
    //   0x008 program counter, 16 bits
    //   0x00C stack pointer, 16 bits
    //   0x010 status, bit 0 busy, bit 3 unknown opcode
    //   0x014 write-back byte, pushed low byte, pushed high byte
    //   0x018 operand a: destination, tested byte, target or popped high
    //   0x01C operand b: source, target or popped low byte
    //   0x354 condition flags, register index D5 times four
    // every register write is refused while an instruction runs, so a
    // late write cannot tear the operands of the instruction in flight
    // unmapped offsets read as zero and ignore writes
    //
    // execution sequence:
    //   write control bit 0 while idle
    //   busy rises at the end of that data phase
    //   busy stands for the cycle count of the opcode
    //   the last busy cycle commits pc, stack pointer, flags and results
    //   result_write pulses for one cycle as busy falls after bit xor, zero and invert
    //
    // flag byte layout:
    //   bit 7 carry, bit 6 zero, bit 5 sign, bit 4 overflow
    //   bit 3 decimal adjust, bit 2 half carry, bits 1:0 unused
    // flags that an opcode leaves undefined keep their old value, so that
    // a run can be repeated and compared bit for bit
    //
    // operand conventions:
    //   bit branch: operand a holds the tested byte, byte 3 the offset
    //   the offset is sign-extended and added to the address after the
    //   three-byte branch, so software keeps targets within -128..+127
    //   bit xor: operand a is the destination, operand b the source;
    //   byte 2 bit 0 picks which side uses the indexed bit
    //   calls: the direct form takes its target from bytes 2 and 3, the
    //   pair and fetched forms take it from operands a and b
    //   the return address is the address after the call, so it depends
    //   on the length of the call; the stack pointer drops by two
    //   return from procedure: operands a and b hold the popped bytes,
    //   high then low, and the stack pointer rises by two
    //   compare: operands keep their values; only flags and pc change
    //
    // limitations:
    //   the block does not reach memory itself; the register file and
    //   stack contents stay outside, and the pushed bytes are only
    //   reported on push_low and push_high for the memory model
    //   the bus has zero wait states and always answers okay
    //   only whole-word transfers are meant; hsize is not decoded
    //   a reset returns every register to its reset value

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        bbcx_state_t st;
        logic [23:0] insn;      // opcode, byte 2, byte 3
        logic [7:0] opa;        // destination / tested operand
        logic [7:0] opb;        // source operand or fetched low target
        logic [7:0] flags;
        logic [15:0] pc;
        logic [15:0] stk;
        logic [3:0] cnt;
        logic [7:0] res;
        logic wr;
        logic [7:0] plo;
        logic [7:0] phi;
        logic illegal;
        logic ap_valid;
        logic ap_write;
        logic [31:0] ap_addr;
        logic [31:0] rdata;
    } bbcx_regs_t;

    bbcx_regs_t r;
    bbcx_regs_t next_r;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // cycle count of an opcode
    function automatic logic [3:0] bbcx_cycles(input logic [7:0] op);
        logic [3:0] c;
        c = CYC_4;
        unique case (op)
            OP_BIT_BRANCH: c = CYC_10;
            OP_BIT_XOR: c = CYC_6;
            OP_CALL_DIRECT, OP_CALL_FETCH: c = CYC_14;
            OP_CALL_PAIR: c = CYC_12;
            OP_RETURN: c = CYC_RET;
            OP_CMP_RIR_W, OP_CMP_RR, OP_CMP_RIR, OP_CMP_LIT: c = CYC_6;
            default: c = CYC_4;
        endcase
        return c;
    endfunction : bbcx_cycles

    // length in bytes of an opcode
    function automatic logic [15:0] bbcx_length(input logic [7:0] op);
        logic [15:0] l;
        l = LEN_2;
        unique case (op)
            OP_BIT_BRANCH, OP_BIT_XOR, OP_CALL_DIRECT: l = LEN_3;
            OP_CMP_RR, OP_CMP_RIR, OP_CMP_LIT: l = LEN_3;
            OP_TOGGLE_CARRY, OP_RETURN: l = LEN_1;
            default: l = LEN_2;
        endcase
        return l;
    endfunction : bbcx_length

    // opcode known to this block
    function automatic logic bbcx_known(input logic [7:0] op);
        logic k;
        k = 1'b0;
        unique case (op)
            OP_BIT_BRANCH, OP_BIT_XOR, OP_CALL_DIRECT, OP_CALL_PAIR, OP_CALL_FETCH,
            OP_RETURN, OP_TOGGLE_CARRY, OP_ZERO_R, OP_ZERO_IND, OP_INVERT_R,
            OP_INVERT_IND, OP_CMP_RR_W, OP_CMP_RIR_W, OP_CMP_RR, OP_CMP_RIR,
            OP_CMP_LIT: k = 1'b1;
            default: k = 1'b0;
        endcase
        return k;
    endfunction : bbcx_known

    // ----------------------------------------------------------------
    // combinational datapath
    // ----------------------------------------------------------------
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic [2:0] bidx;
    logic [8:0] diff;
    logic [15:0] pc_after;
    logic bus_ap;
    logic [31:0] wr_data;

    assign op = r.insn[23:16];
    assign b2 = r.insn[15:8];
    assign b3 = r.insn[7:0];
    assign bidx = b2[3:1];
    assign diff = {1'b0, r.opa} - {1'b0, r.opb};
    assign pc_after = r.pc + bbcx_length(op);
    assign bus_ap = hsel && hready && htrans[1];
    assign wr_data = hwdata;

    // next-state process: bus slave and execution
    always_comb
    begin
        next_r = r;
        next_r.wr = 1'b0;
        next_r.ap_valid = bus_ap;
        next_r.ap_write = hwrite;
        next_r.ap_addr = haddr;
        // register writes happen in the data phase
        if (r.ap_valid && r.ap_write && r.st == BBCX_IDLE)
        begin
            unique case (r.ap_addr)
                ADDR_INSN: next_r.insn = wr_data[23:0];
                ADDR_OPA: next_r.opa = wr_data[7:0];
                ADDR_OPB: next_r.opb = wr_data[7:0];
                ADDR_PC: next_r.pc = wr_data[15:0];
                ADDR_STACK: next_r.stk = wr_data[15:0];
                ADDR_FLAGS: next_r.flags = wr_data[7:0];
                ADDR_CTRL:
                begin
                    if (wr_data[0])
                    begin
                        next_r.st = BBCX_EXEC;
                        next_r.cnt = bbcx_cycles(op) - 4'd1;
                        next_r.illegal = !bbcx_known(op);
                    end
                end
                default: ;
            endcase
        end
        // read data captured at address phase
        unique case (haddr)
            ADDR_INSN: next_r.rdata = {8'h00, r.insn};
            ADDR_OPA: next_r.rdata = {24'h000000, r.opa};
            ADDR_OPB: next_r.rdata = {24'h000000, r.opb};
            ADDR_PC: next_r.rdata = {16'h0000, r.pc};
            ADDR_STACK: next_r.rdata = {16'h0000, r.stk};
            ADDR_FLAGS: next_r.rdata = {24'h000000, r.flags};
            ADDR_RESULT: next_r.rdata = {8'h00, r.phi, r.plo, r.res};
            ADDR_STATUS: next_r.rdata = {28'h0000000, r.illegal, 2'b00, r.st != BBCX_IDLE};
            default: next_r.rdata = 32'h0000_0000;
        endcase
        // execution: count cycles, then commit
        unique case (r.st)
            BBCX_IDLE: ;
            BBCX_EXEC:
            begin
                if (r.cnt > 4'd1)
                    next_r.cnt = r.cnt - 4'd1;
                else
                    next_r.st = BBCX_DONE;
            end
            BBCX_DONE:
            begin
                next_r.st = BBCX_IDLE;
                next_r.pc = pc_after;
                if (!r.illegal)
                begin
                    unique case (op)
                        OP_BIT_BRANCH:
                        begin
                            // low bit of byte 2 picks set or clear test
                            if (r.opa[bidx] == b2[0])
                                next_r.pc = pc_after + {{8{b3[7]}}, b3};
                        end
                        OP_BIT_XOR:
                        begin
                            next_r.res = r.opa;
                            if (b2[0])
                                next_r.res[bidx] = r.opa[bidx] ^ r.opb[0];
                            else
                                next_r.res[0] = r.opa[0] ^ r.opb[bidx];
                            next_r.wr = 1'b1;
                            next_r.flags[FLAG_Z] = b2[0] ? !(r.opa[bidx] ^ r.opb[0])
                                                         : !(r.opa[0] ^ r.opb[bidx]);
                            next_r.flags[FLAG_S] = 1'b0;
                        end
                        OP_CALL_DIRECT, OP_CALL_PAIR, OP_CALL_FETCH:
                        begin
                            next_r.plo = pc_after[7:0];
                            next_r.phi = pc_after[15:8];
                            next_r.stk = r.stk - 16'd2;
                            if (op == OP_CALL_DIRECT)
                                next_r.pc = {b2, b3};
                            else
                                next_r.pc = {r.opa, r.opb};
                        end
                        OP_RETURN:
                        begin
                            next_r.pc = {r.opa, r.opb};
                            next_r.stk = r.stk + 16'd2;
                        end
                        OP_TOGGLE_CARRY: next_r.flags[FLAG_C] = !r.flags[FLAG_C];
                        OP_ZERO_R, OP_ZERO_IND:
                        begin
                            next_r.res = 8'h00;
                            next_r.wr = 1'b1;
                        end
                        OP_INVERT_R, OP_INVERT_IND:
                        begin
                            next_r.res = ~r.opa;
                            next_r.wr = 1'b1;
                            next_r.flags[FLAG_Z] = (r.opa == 8'hFF);
                            next_r.flags[FLAG_S] = !r.opa[7];
                            next_r.flags[FLAG_V] = 1'b0;
                        end
                        OP_CMP_RR_W, OP_CMP_RIR_W, OP_CMP_RR, OP_CMP_RIR, OP_CMP_LIT:
                        begin
                            // no write-back of either operand
                            next_r.flags[FLAG_C] = diff[8];
                            next_r.flags[FLAG_Z] = (diff[7:0] == 8'h00);
                            next_r.flags[FLAG_S] = diff[7];
                            next_r.flags[FLAG_V] = (r.opa[7] != r.opb[7])
                                                   && (diff[7] != r.opa[7]);
                        end
                        default: ;
                    endcase
                end
            end
            default: next_r.st = BBCX_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            r <= '0;
            r.st <= BBCX_IDLE;
            r.flags <= FLAGS_RESET;
            r.pc <= PC_RESET;
            r.stk <= STACK_RESET;
        end
        else
            r <= next_r;
    end

    // outputs
    assign hrdata = r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign busy = (r.st != BBCX_IDLE);
    assign result = r.res;
    assign result_write = r.wr;
    assign push_low = r.plo;
    assign push_high = r.phi;
endmodule : bbcx_exec

// ==== bbcx_pkg.sv ====
package bbcx_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses on the bus)
    // ----------------------------------------------------------------
    localparam logic [7:0] FLAGS_REG_ADDR = 8'hD5;
    localparam logic [31:0] ADDR_FLAGS = 32'h0000_00D5 << 2;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_INSN = 32'h0000_0004;
    localparam logic [31:0] ADDR_PC = 32'h0000_0008;
    localparam logic [31:0] ADDR_STACK = 32'h0000_000C;
    localparam logic [31:0] ADDR_STATUS = 32'h0000_0010;
    localparam logic [31:0] ADDR_RESULT = 32'h0000_0014;
    localparam logic [31:0] ADDR_OPA = 32'h0000_0018;
    localparam logic [31:0] ADDR_OPB = 32'h0000_001C;
    // ----------------------------------------------------------------
    // flag bit positions
    // ----------------------------------------------------------------
    localparam int FLAG_C = 7;
    localparam int FLAG_Z = 6;
    localparam int FLAG_S = 5;
    localparam int FLAG_V = 4;
    localparam int FLAG_D = 3;
    localparam int FLAG_H = 2;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] STACK_RESET = 16'h0000;
    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_BIT_BRANCH = 8'h37;
    localparam logic [7:0] OP_BIT_XOR = 8'h27;
    localparam logic [7:0] OP_CALL_DIRECT = 8'hF6;
    localparam logic [7:0] OP_CALL_PAIR = 8'hF4;
    localparam logic [7:0] OP_CALL_FETCH = 8'hD4;
    localparam logic [7:0] OP_RETURN = 8'hAF;
    localparam logic [7:0] OP_TOGGLE_CARRY = 8'hEF;
    localparam logic [7:0] OP_ZERO_R = 8'hB0;
    localparam logic [7:0] OP_ZERO_IND = 8'hB1;
    localparam logic [7:0] OP_INVERT_R = 8'h60;
    localparam logic [7:0] OP_INVERT_IND = 8'h61;
    localparam logic [7:0] OP_CMP_RR_W = 8'hA2;
    localparam logic [7:0] OP_CMP_RIR_W = 8'hA3;
    localparam logic [7:0] OP_CMP_RR = 8'hA4;
    localparam logic [7:0] OP_CMP_RIR = 8'hA5;
    localparam logic [7:0] OP_CMP_LIT = 8'hA6;
    // ----------------------------------------------------------------
    // cycle counts and lengths
    // ----------------------------------------------------------------
    localparam logic [3:0] CYC_4 = 4'd4;
    localparam logic [3:0] CYC_6 = 4'd6;
    localparam logic [3:0] CYC_10 = 4'd10;
    localparam logic [3:0] CYC_12 = 4'd12;
    localparam logic [3:0] CYC_14 = 4'd14;
    localparam logic [3:0] CYC_RET = 4'd8;
    localparam logic [15:0] LEN_1 = 16'd1;
    localparam logic [15:0] LEN_2 = 16'd2;
    localparam logic [15:0] LEN_3 = 16'd3;
    localparam logic [3:0] ERR_BIT = 4'd1;
    typedef enum logic [1:0] {BBCX_IDLE, BBCX_EXEC, BBCX_DONE} bbcx_state_t;
endpackage : bbcx_pkg

// ==== bbcx_exec_asserts.sv ====
`timescale 1ns/1ps
module bbcx_exec_chk
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // watched outputs
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic busy,
    input wire logic [7:0] result,
    input wire logic result_write,
    input wire logic [7:0] push_low,
    input wire logic [7:0] push_high
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // ----------------------------------------------------------------
    // bus answer and execution timing
    // ----------------------------------------------------------------
    chk_zero_wait: assert property (hreadyout)
        else $error("hreadyout dropped");
    chk_okay_resp: assert property (!hresp)
        else $error("hresp not okay");
    chk_wb_commit: assert property (result_write |-> $fell(busy))
        else $error("write-back outside commit");
    chk_wb_pulse: assert property (result_write |=> !result_write)
        else $error("write-back longer than one cycle");
    chk_busy_min: assert property ($rose(busy) |-> busy [*4])
        else $error("instruction shorter than four cycles");
    chk_busy_max: assert property ($rose(busy) |-> ##[4:16] !busy)
        else $error("instruction longer than sixteen cycles");
    chk_push_hold: assert property ($changed({push_high, push_low}) |-> $fell(busy))
        else $error("pushed bytes moved outside commit");
    chk_result_hold: assert property ($changed(result) |-> $fell(busy))
        else $error("result moved outside commit");
    // main scenarios reached
    cover property (result_write);
    cover property ($fell(busy) && !result_write);
    cover property ($changed(push_low));
endmodule : bbcx_exec_chk

bind bbcx_exec bbcx_exec_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
    .hresp(hresp), .busy(busy), .result(result), .result_write(result_write),
    .push_low(push_low), .push_high(push_high));

// ==== bbcx_sink.sv ====
`timescale 1ns/1ps
module bbcx_sink
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // write-back from the block
    input wire logic result_write,
    input wire logic [7:0] result,
    // register file view
    output logic [7:0] last_wb,
    output logic [15:0] wb_count
);
    // destination register takes each written-back value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            last_wb <= 8'h00;
            wb_count <= 16'h0000;
        end
        else if (result_write)
        begin
            last_wb <= result;
            wb_count <= wb_count + 16'h0001;
        end
    end
endmodule : bbcx_sink

// ==== bit_branch_call_compare_exec_tb_top.sv ====
`timescale 1ns/1ps
module bit_branch_call_compare_exec_tb_top;
    import bbcx_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hrdy;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rnd = 32'hA8E7430B;
    logic hreadyout, hresp, busy, result_write;
    logic [7:0] result, push_low, push_high, last_wb, rexp = 8'h00;
    logic [15:0] wb_count, pexp = 16'h0000, nwb = 16'h0000;
    logic [7:0] q_exp [$];
    int checks = 0, failures = 0, bcnt = 0, blen = 0, tick = 0;
    logic [7:0] ops [16] = '{OP_BIT_BRANCH, OP_BIT_XOR, OP_CALL_DIRECT, OP_CALL_PAIR,
        OP_CALL_FETCH, OP_RETURN, OP_TOGGLE_CARRY, OP_ZERO_R, OP_ZERO_IND, OP_INVERT_R,
        OP_INVERT_IND, OP_CMP_RR_W, OP_CMP_RIR_W, OP_CMP_RR, OP_CMP_RIR, OP_CMP_LIT};
    assign hrdy = hreadyout;
    bbcx_exec dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hrdy), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy), .result(result),
        .result_write(result_write), .push_low(push_low), .push_high(push_high));
    bbcx_sink sink_u (.hclk(hclk), .hresetn(hresetn), .result_write(result_write),
        .result(result), .last_wb(last_wb), .wb_count(wb_count));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic conclude;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : conclude
    // one single ahb-lite transfer, held until hready
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= a;
        do @(posedge hclk); while (hrdy !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask : wr
    // one instruction with random operands, expectations from the flag rules
    task automatic run(input logic [7:0] op);
        logic [31:0] q;
        logic [7:0] a, b, b2, b3, fl, f, r, xr;
        logic [15:0] pc, stk, p, s;
        logic [8:0] dif;
        logic [3:0] cy;
        logic [2:0] bi;
        logic wb;
        {a, b, b2, b3} = rnd; // full signed offset range only
        rnd = xs(rnd);
        {pc, stk} = rnd;
        rnd = xs(rnd);
        fl = rnd[7:0];
        rnd = xs(rnd);
        bi = b2[3:1];
        xr = b2[0] ? (a ^ ({7'h00, b[0]} << bi)) : {a[7:1], a[0] ^ b[bi]};
        dif = {1'b0, a} - {1'b0, b};
        {f, p, s, wb, r, cy} = {fl, pc + LEN_3, stk, 1'b0, rexp, CYC_6};
        case (op)
            OP_BIT_BRANCH: {p, cy} = {pc + LEN_3 + ((a[bi] == b2[0]) ? {{8{b3[7]}}, b3}
                : 16'h0000), CYC_10}; // both polarities
            OP_BIT_XOR: {wb, r, f[FLAG_Z], f[FLAG_S]} = {1'b1, xr,
                ~(b2[0] ? xr[bi] : xr[0]), 1'b0};
            OP_CALL_DIRECT: {p, s, pexp, cy} = {b2, b3, stk - 16'h0002, pc + LEN_3, CYC_14};
            OP_CALL_PAIR: {p, s, pexp, cy} = {a, b, stk - 16'h0002, pc + LEN_2, CYC_12};
            OP_CALL_FETCH: {p, s, pexp, cy} = {a, b, stk - 16'h0002, pc + LEN_2, CYC_14};
            OP_RETURN: {p, s, cy} = {a, b, stk + 16'h0002, CYC_RET};
            OP_TOGGLE_CARRY: {p, f[FLAG_C], cy} = {pc + LEN_1, ~fl[FLAG_C], CYC_4};
            OP_ZERO_R, OP_ZERO_IND: {wb, p, r, cy} = {1'b1, pc + LEN_2, 8'h00, CYC_4};
            OP_INVERT_R, OP_INVERT_IND: {wb, p, r, f[7:4], cy} = {1'b1, pc + LEN_2, ~a,
                fl[FLAG_C], a == 8'hFF, ~a[7], 1'b0, CYC_4};
            OP_CMP_RR_W: {p, f[7:4], cy} = {pc + LEN_2, dif[8], dif[7:0] == 8'h00, dif[7],
                (a[7] != b[7]) && (dif[7] != a[7]), CYC_4};
            default: {p, f[7:4], cy} = {pc + ((op == OP_CMP_RIR_W) ? LEN_2 : LEN_3), dif[8],
                dif[7:0] == 8'h00, dif[7], (a[7] != b[7]) && (dif[7] != a[7]), CYC_6};
        endcase
        if (wb)
            q_exp.push_back(r);
        nwb += {15'h0000, wb};
        rexp = r;
        wr(ADDR_FLAGS, {24'h0, fl});
        xfer(1'b0, ADDR_FLAGS, 32'h0, q);
        check("flags_rw", q, {24'h0, fl});
        wr(ADDR_PC, {16'h0, pc});
        wr(ADDR_STACK, {16'h0, stk});
        wr(ADDR_INSN, {8'h00, op, b2, b3});
        wr(ADDR_OPA, {24'h0, a});
        wr(ADDR_OPB, {24'h0, b});
        wr(ADDR_CTRL, 32'h1);
        wr(ADDR_OPA, {24'h0, ~a});
        q = 32'h1;
        for (int n = 0; n < 40 && q[0] !== 1'b0; n++) xfer(1'b0, ADDR_STATUS, 32'h0, q);
        check("status", q & 32'h9, 32'h0);
        xfer(1'b0, ADDR_PC, 32'h0, q);
        check("pc", q, {16'h0, p});
        xfer(1'b0, ADDR_STACK, 32'h0, q);
        check("sp", q, {16'h0, s});
        xfer(1'b0, ADDR_FLAGS, 32'h0, q);
        check("flags", q, {24'h0, f});
        xfer(1'b0, ADDR_RESULT, 32'h0, q);
        check("result_reg", q, {8'h0, pexp, rexp});
        xfer(1'b0, ADDR_OPA, 32'h0, q);
        check("opa", q, {24'h0, a});
        check("cycles", blen, 32'(cy));
    endtask : run
    // ----------------------------------------------------------------
    // clock, reset and stimulus
    // ----------------------------------------------------------------
    initial
    begin
        forever #5 hclk = ~hclk;
    end
    // watcher: busy length, write-back results, timeout
    always @(posedge hclk)
    begin
        tick++;
        if (busy === 1'b1)
            bcnt <= bcnt + 1;
        else if (bcnt != 0)
            {blen, bcnt} <= {bcnt, 32'h0};
        if (result_write === 1'b1)
            check("result", {24'h0, result}, {24'h0, q_exp.size() ? q_exp.pop_front() : 8'hXX});
        if (tick == 20000)
        begin
            failures++;
            conclude();
        end
    end
    // main sequence
    initial
    begin
        logic [31:0] q;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        for (int k = 0; k < 3; k++)
        begin
            foreach (ops[i]) run(ops[i]);
            $display("test round %0d done", k);
        end
        xfer(1'b0, 32'h0000_0100, 32'h0, q);
        check("unmapped", q, 32'h0);
        check("writebacks", {16'h0, wb_count}, {16'h0, nwb});
        $display("test unmapped and write-back count done");
        conclude();
    end
endmodule : bit_branch_call_compare_exec_tb_top
